// file: ddr2_timing_pkg.sv
// command codes, pin bundle and timing constants for the ddr2 command controller
package ddr2_timing_pkg;

  localparam int CLK_PS      = 5000;
  localparam int MIN_CYC     = 2;
  localparam int RRD_PS      = 7500;
  localparam int CCD_CYC     = 2;
  localparam int WR_PS       = 15000;
  localparam int WTR_PS      = 7500;
  localparam int RTP_PS      = 7500;
  localparam int CKE_CYC     = 3;
  localparam int XSNR_ADD_PS = 10000;
  localparam int XSRD_CYC    = 200;
  localparam int XP_CYC      = 2;
  localparam int XARD_CYC    = 2;
  localparam int XARDS_667   = 7;
  localparam int XARDS_800   = 8;
  localparam int ANPD_CYC    = 3;
  localparam int AXPD_CYC    = 8;
  localparam int MRD_CYC     = 2;
  localparam int TIS_PS      = 200;
  localparam int TIH_PS      = 275;
  // array timings not fixed by the command table; plain defaults
  localparam int RP_PS       = 15000;
  localparam int RAS_PS      = 40000;
  localparam int RFC_PS      = 75000;

  localparam int MR_SLOW_BIT = 12;
  localparam int EMR_DQS_BIT = 10;
  localparam int AP_BIT      = 10;
  localparam logic [1:0] BA_MR  = 2'h0;
  localparam logic [1:0] BA_EMR = 2'h1;

  // ps minimum rounded up to whole cycles, never below the cycle floor
  function automatic int cyc_up(input int ps, input int lo);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < lo) ? lo : c;
  endfunction : cyc_up

  localparam int RRD_CYC  = cyc_up(RRD_PS, MIN_CYC);
  localparam int WR_CYC   = cyc_up(WR_PS, 1);
  localparam int WTR_CYC  = cyc_up(WTR_PS, 1);
  localparam int RTP_CYC  = cyc_up(RTP_PS, 1);
  localparam int RP_CYC   = cyc_up(RP_PS, 1);
  localparam int RAS_CYC  = cyc_up(RAS_PS, 1);
  localparam int XSNR_CYC = cyc_up(RFC_PS + XSNR_ADD_PS, 1);
  localparam int DLY_CYC  = cyc_up(TIS_PS + CLK_PS + TIH_PS, 1);

  typedef logic [7:0] cnt_t;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_WRA, CMD_PRE,
    CMD_REF, CMD_MRS, CMD_SRE, CMD_PDE, CMD_EXIT
  } cmd_t;

  typedef struct packed {
    cmd_t        cmd;
    logic [1:0]  ba;
    logic [12:0] addr;
  } req_t;

  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic        odt;
  } ddr_bus_t;

endpackage : ddr2_timing_pkg

// file: ddr2_cmd_ctrl.sv
// ddr2 command issuer that enforces device command spacing
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - activates at least 7.5 ns, two cycles apart
// - column commands at least two cycles apart
// - write-autoprecharge waits recovery plus precharge
// - write data end to read 7.5 ns
// - read to precharge at least 7.5 ns
// - read to precharge also AL plus BL/2
// - clock enable high and low three cycles
// - self refresh exit, refresh time plus 10 ns
// - self refresh exit, 200 cycles before read
// - precharge power down exit, two cycles
// - fast active power down exit, read after two
// - slow exit, read after 7/8 minus AL
// - mode register A12 picks exit speed
// - termination stable three cycles before power down
// - termination held eight cycles after power down exit
// - mode register set, two cycles to next
// - clock runs setup plus period plus hold
// - extended mode bit picks strobe single or differential
module ddr2_cmd_ctrl
  import ddr2_timing_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // user command port
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire req_t       req,
  // operating settings
  input  wire logic [2:0] cfg_al,
  input  wire logic [2:0] cfg_cl,
  input  wire logic       cfg_bl8,
  input  wire logic       cfg_grade800,
  input  wire logic       odt_req,
  // memory pins and mode status
  output var  ddr_bus_t   ddr,
  output logic            ck_en,
  output logic            dqs_se,
  output logic            slow_exit
);

  typedef enum logic [1:0] {ST_RUN, ST_SREF, ST_PDN} pst_t;

  function automatic cnt_t dn(input cnt_t x);
    return (x == 8'h00) ? 8'h00 : x - 8'h01;
  endfunction : dn

  function automatic cnt_t umax(input cnt_t a, input cnt_t b);
    return (a > b) ? a : b;
  endfunction : umax

  function automatic logic is_col(input cmd_t c);
    return (c == CMD_RD) || (c == CMD_WR) || (c == CMD_WRA);
  endfunction : is_col

  ////////////////////////////////////////////////////////////////////////////
  pst_t state_r, state_nxt;
  logic pd_act_r, pd_act_nxt, slow_r, slow_nxt, dqs_se_r, dqs_se_nxt;
  logic odt_r, odt_nxt, ck_en_r, ck_en_nxt;
  cnt_t rrd_r, rrd_nxt, ccd_r, ccd_nxt, wtr_r, wtr_nxt, mrd_r, mrd_nxt;
  cnt_t any_r, any_nxt, rd_r, rd_nxt, cke_r, cke_nxt, axpd_r, axpd_nxt;
  cnt_t dly_r, dly_nxt, age_r, age_nxt;
  ddr_bus_t ddr_r, ddr_nxt;
  logic [3:0] open_v, act_z, pre_z;
  logic       take;
  cnt_t       bl2, wl, rtp_ld, wr_ld, dal_ld, xards;

  assign take = req_valid && req_ready;

  always_comb begin
    bl2    = cfg_bl8 ? 8'h04 : 8'h02;
    wl     = cnt_t'(cfg_al) + cnt_t'(cfg_cl) - 8'h01;
    rtp_ld = umax(cnt_t'(cfg_al) + bl2, cnt_t'(RTP_CYC)) - 8'h01;
    wr_ld  = wl + bl2 + cnt_t'(WR_CYC) - 8'h01;
    dal_ld = wl + bl2 + cnt_t'(WR_CYC + RP_CYC) - 8'h01;
    xards  = umax((cfg_grade800 ? cnt_t'(XARDS_800) : cnt_t'(XARDS_667))
                  - cnt_t'(cfg_al), 8'h01);
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-bank open state, activate gate and precharge gate
  generate
    for (genvar b = 0; b < 4; b++) begin : g_bank
      cnt_t act_r, act_nxt, pre_r, pre_nxt;
      logic opn_r, opn_nxt, hit;
      assign hit      = take && (req.ba == 2'(b));
      assign open_v[b] = opn_r;
      assign act_z[b]  = (act_r == 8'h00);
      assign pre_z[b]  = (pre_r == 8'h00);
      always_comb begin
        act_nxt = dn(act_r);
        pre_nxt = dn(pre_r);
        opn_nxt = opn_r;
        if (hit && req.cmd == CMD_ACT) begin
          opn_nxt = 1'b1;
          pre_nxt = cnt_t'(RAS_CYC - 1);
        end
        if (hit && req.cmd == CMD_RD) pre_nxt = umax(pre_nxt, rtp_ld);
        if (hit && req.cmd == CMD_WR) pre_nxt = umax(pre_nxt, wr_ld);
        if (hit && req.cmd == CMD_WRA) begin
          opn_nxt = 1'b0;
          act_nxt = dal_ld;
        end
        if (take && req.cmd == CMD_PRE && (hit || req.addr[AP_BIT])) begin
          opn_nxt = 1'b0;
          act_nxt = umax(act_nxt, cnt_t'(RP_CYC - 1));
        end
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          act_r <= 8'h00;
          pre_r <= 8'h00;
          opn_r <= 1'b0;
        end else begin
          act_r <= act_nxt;
          pre_r <= pre_nxt;
          opn_r <= opn_nxt;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // acceptance: a request waits at the port until every gate is open
  logic gen_ok, cke_ok, odt_ok, idle_ok;
  always_comb begin
    gen_ok  = (any_r == 8'h00) && (mrd_r == 8'h00);
    cke_ok  = (cke_r == 8'h00);
    odt_ok  = (age_r >= cnt_t'(ANPD_CYC)) && (odt_req == odt_r);
    idle_ok = (open_v == 4'h0) && (act_z == 4'hF);
    req_ready = 1'b0;
    if (state_r == ST_RUN) begin
      case (req.cmd)
        CMD_NOP: req_ready = 1'b1;
        CMD_ACT: req_ready = gen_ok && (rrd_r == 8'h00) && act_z[req.ba]
                             && !open_v[req.ba];
        CMD_RD:  req_ready = (mrd_r == 8'h00) && (rd_r == 8'h00) && (ccd_r == 8'h00)
                             && (wtr_r == 8'h00) && open_v[req.ba];
        CMD_WR, CMD_WRA: req_ready = gen_ok && (ccd_r == 8'h00) && open_v[req.ba];
        CMD_PRE: req_ready = gen_ok && (req.addr[AP_BIT] ? (pre_z == 4'hF) : pre_z[req.ba]);
        CMD_REF, CMD_MRS: req_ready = gen_ok && idle_ok;
        CMD_SRE: req_ready = gen_ok && idle_ok && cke_ok && odt_ok;
        CMD_PDE: req_ready = gen_ok && cke_ok && odt_ok && (pre_z == 4'hF);
        default: req_ready = 1'b0;
      endcase
    end else begin
      req_ready = (req.cmd == CMD_EXIT) && cke_ok && ck_en_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spacing counters, power state and mode tracking
  always_comb begin
    state_nxt  = state_r;
    pd_act_nxt = pd_act_r;
    slow_nxt   = slow_r;
    dqs_se_nxt = dqs_se_r;
    rrd_nxt    = (take && req.cmd == CMD_ACT) ? cnt_t'(RRD_CYC - 1) : dn(rrd_r);
    ccd_nxt    = (take && is_col(req.cmd)) ? cnt_t'(CCD_CYC - 1) : dn(ccd_r);
    wtr_nxt    = (take && (req.cmd == CMD_WR || req.cmd == CMD_WRA))
                 ? wl + bl2 + cnt_t'(WTR_CYC - 1) : dn(wtr_r);
    mrd_nxt    = (take && req.cmd == CMD_MRS) ? cnt_t'(MRD_CYC - 1) : dn(mrd_r);
    cke_nxt    = (take && (req.cmd == CMD_SRE || req.cmd == CMD_PDE || req.cmd == CMD_EXIT))
                 ? cnt_t'(CKE_CYC - 1) : dn(cke_r);
    any_nxt    = dn(any_r);
    rd_nxt     = dn(rd_r);
    axpd_nxt   = dn(axpd_r);
    dly_nxt    = dn(dly_r);
    if (take) begin
      case (req.cmd)
        CMD_SRE: begin
          state_nxt = ST_SREF;
          dly_nxt   = cnt_t'(DLY_CYC - 1);
        end
        CMD_PDE: begin
          state_nxt  = ST_PDN;
          pd_act_nxt = |open_v;
        end
        CMD_EXIT: begin
          state_nxt = ST_RUN;
          if (state_r == ST_SREF) begin
            any_nxt = cnt_t'(XSNR_CYC - 1);
            rd_nxt  = cnt_t'(XSRD_CYC - 1);
          end else begin
            any_nxt  = cnt_t'(XP_CYC - 1);
            axpd_nxt = cnt_t'(AXPD_CYC - 1);
            if (!pd_act_r) rd_nxt = cnt_t'(XP_CYC - 1);
            else if (slow_r) rd_nxt = xards - 8'h01;
            else rd_nxt = cnt_t'(XARD_CYC - 1);
          end
        end
        CMD_MRS: begin
          if (req.ba == BA_MR) slow_nxt = req.addr[MR_SLOW_BIT];
          if (req.ba == BA_EMR) dqs_se_nxt = req.addr[EMR_DQS_BIT];
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  // termination follows the request only while running and past the exit latency
  always_comb begin
    odt_nxt = odt_r;
    age_nxt = (age_r < cnt_t'(ANPD_CYC)) ? age_r + 8'h01 : age_r;
    if (state_r == ST_RUN && axpd_r == 8'h00 && odt_req != odt_r) begin
      odt_nxt = odt_req;
      age_nxt = 8'h00;
    end
  end

  // the device clock stops only in self refresh, and restarts before exit is accepted
  always_comb begin
    ck_en_nxt = ck_en_r;
    if (state_r != ST_SREF) ck_en_nxt = 1'b1;
    else if (req_valid && req.cmd == CMD_EXIT) ck_en_nxt = 1'b1;
    else if (dly_r == 8'h00) ck_en_nxt = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin encoding
  always_comb begin
    ddr_nxt       = ddr_r;
    ddr_nxt.cke   = (state_nxt == ST_RUN);
    ddr_nxt.cs_n  = 1'b0;
    {ddr_nxt.ras_n, ddr_nxt.cas_n, ddr_nxt.we_n} = 3'h7;
    ddr_nxt.odt   = odt_nxt;
    if (take && req.cmd != CMD_NOP) begin
      ddr_nxt.ba   = req.ba;
      ddr_nxt.addr = req.addr;
      case (req.cmd)
        CMD_ACT: {ddr_nxt.ras_n, ddr_nxt.cas_n, ddr_nxt.we_n} = 3'h3;
        CMD_RD: begin
          {ddr_nxt.ras_n, ddr_nxt.cas_n, ddr_nxt.we_n} = 3'h5;
          ddr_nxt.addr[AP_BIT] = 1'b0;
        end
        CMD_WR, CMD_WRA: begin
          {ddr_nxt.ras_n, ddr_nxt.cas_n, ddr_nxt.we_n} = 3'h4;
          ddr_nxt.addr[AP_BIT] = (req.cmd == CMD_WRA);
        end
        CMD_PRE: {ddr_nxt.ras_n, ddr_nxt.cas_n, ddr_nxt.we_n} = 3'h2;
        CMD_REF, CMD_SRE: {ddr_nxt.ras_n, ddr_nxt.cas_n, ddr_nxt.we_n} = 3'h1;
        CMD_MRS: {ddr_nxt.ras_n, ddr_nxt.cas_n, ddr_nxt.we_n} = 3'h0;
        default: ddr_nxt.cs_n = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r  <= ST_RUN;
      pd_act_r <= 1'b0;
      slow_r   <= 1'b0;
      dqs_se_r <= 1'b0;
      odt_r    <= 1'b0;
      ck_en_r  <= 1'b1;
      rrd_r    <= 8'h00;
      ccd_r    <= 8'h00;
      wtr_r    <= 8'h00;
      mrd_r    <= 8'h00;
      any_r    <= 8'h00;
      rd_r     <= 8'h00;
      cke_r    <= 8'h00;
      axpd_r   <= 8'h00;
      dly_r    <= 8'h00;
      age_r    <= 8'h00;
      ddr_r    <= '{cke: 1'b1, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                    ba: 2'h0, addr: 13'h0000, odt: 1'b0};
    end else begin
      state_r  <= state_nxt;
      pd_act_r <= pd_act_nxt;
      slow_r   <= slow_nxt;
      dqs_se_r <= dqs_se_nxt;
      odt_r    <= odt_nxt;
      ck_en_r  <= ck_en_nxt;
      rrd_r    <= rrd_nxt;
      ccd_r    <= ccd_nxt;
      wtr_r    <= wtr_nxt;
      mrd_r    <= mrd_nxt;
      any_r    <= any_nxt;
      rd_r     <= rd_nxt;
      cke_r    <= cke_nxt;
      axpd_r   <= axpd_nxt;
      dly_r    <= dly_nxt;
      age_r    <= age_nxt;
      ddr_r    <= ddr_nxt;
    end
  end

  assign ddr       = ddr_r;
  assign ck_en     = ck_en_r;
  assign dqs_se    = dqs_se_r;
  assign slow_exit = slow_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the pins as driven
  logic d_cmd, d_act, d_col, d_rd, d_mrs;
  cnt_t h_act, h_col, h_cke, h_srx;
  assign d_cmd = ddr_r.cke && !ddr_r.cs_n && ({ddr_r.ras_n, ddr_r.cas_n, ddr_r.we_n} != 3'h7);
  assign d_act = d_cmd && ({ddr_r.ras_n, ddr_r.cas_n, ddr_r.we_n} == 3'h3);
  assign d_col = d_cmd && !ddr_r.cas_n && ddr_r.ras_n;
  assign d_rd  = d_col && ddr_r.we_n;
  assign d_mrs = d_cmd && ({ddr_r.ras_n, ddr_r.cas_n, ddr_r.we_n} == 3'h0);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      h_act <= 8'hFF;
      h_col <= 8'hFF;
      h_cke <= 8'hFF;
      h_srx <= 8'hFF;
    end else begin
      h_act <= d_act ? 8'h01 : ((h_act == 8'hFF) ? h_act : h_act + 8'h01);
      h_col <= d_col ? 8'h01 : ((h_col == 8'hFF) ? h_col : h_col + 8'h01);
      h_cke <= (ddr_nxt.cke != ddr_r.cke) ? 8'h01 : ((h_cke == 8'hFF) ? h_cke : h_cke + 8'h01);
      h_srx <= (take && req.cmd == CMD_EXIT && state_r == ST_SREF) ? 8'h00
               : ((h_srx == 8'hFF) ? h_srx : h_srx + 8'h01);
    end
  end

  sequence s_mrs_sent;
    d_mrs;
  endsequence
  sequence s_cke_fall;
    $fell(ddr_r.cke) && state_r == ST_SREF;
  endsequence

  property p_rrd;
    @(posedge clk_sys) disable iff (rst) d_act |-> h_act >= cnt_t'(RRD_CYC);
  endproperty
  a_rrd: assert property (p_rrd) else $error("activates too close");
  property p_ccd;
    @(posedge clk_sys) disable iff (rst) d_col |-> h_col >= cnt_t'(CCD_CYC);
  endproperty
  a_ccd: assert property (p_ccd) else $error("column commands too close");
  property p_cke;
    @(posedge clk_sys) disable iff (rst) $changed(ddr_r.cke) |-> $past(h_cke) >= cnt_t'(CKE_CYC);
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable pulse too short");
  property p_mrd;
    @(posedge clk_sys) disable iff (rst) s_mrs_sent |=> !d_cmd;
  endproperty
  a_mrd: assert property (p_mrd) else $error("command right after mode set");
  property p_xsrd;
    @(posedge clk_sys) disable iff (rst) d_rd |-> h_srx >= cnt_t'(XSRD_CYC);
  endproperty
  a_xsrd: assert property (p_xsrd) else $error("read too soon after self refresh");
  property p_slow;
    @(posedge clk_sys) disable iff (rst)
      (take && req.cmd == CMD_MRS && req.ba == BA_MR) |=> slow_exit == $past(req.addr[MR_SLOW_BIT]);
  endproperty
  a_slow: assert property (p_slow) else $error("exit speed not captured");
  property p_odt_pd;
    @(posedge clk_sys) disable iff (rst)
      $fell(ddr_r.cke) |-> $stable(ddr_r.odt) && ddr_r.odt == $past(ddr_r.odt, 3);
  endproperty
  a_odt_pd: assert property (p_odt_pd) else $error("termination moved before power down");
  property p_delay;
    @(posedge clk_sys) disable iff (rst) s_cke_fall |-> ck_en ##1 ck_en;
  endproperty
  a_delay: assert property (p_delay) else $error("device clock stopped too early");

endmodule : ddr2_cmd_ctrl

`default_nettype wire

// file: ddr2_dev_model.sv
// behavioural memory device that watches command spacing on its pins
`timescale 1ns/1ps
`default_nettype none
module ddr2_dev_model
  import ddr2_timing_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // pins and operating settings
  input  wire ddr_bus_t   ddr,
  input  wire logic       ck_en,
  input  wire logic [2:0] cfg_al,
  input  wire logic [2:0] cfg_cl,
  input  wire logic       cfg_bl8,
  input  wire logic       cfg_grade800,
  // device status
  output var  int         faults,
  output var  logic       slow_mode,
  output var  logic       se_strobe
);
  int         now, t_act, t_col, t_mrd, t_cke, t_xsr, t_xpd, t_odt, t_wtr, bl2, wl, lim;
  int         t_rd [4];
  int         t_ras [4];
  int         t_dal [4];
  logic [3:0] opn;
  logic       pcke, podt, in_sr, act_pd;
  logic [2:0] c;

  task automatic chk(input bit ok, input string m);
    if (!ok) begin
      faults++;
      $display("ERROR %0t device saw %s", $time, m);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  // event times start far in the past and deadlines at zero, so the first command after reset is always legal
  always @(posedge clk_sys) begin
    if (rst) begin
      now = 0;
      faults = 0;
      t_wtr = 0;
      t_act = -999;
      t_col = -999;
      t_mrd = -999;
      t_cke = -999;
      t_xsr = -999;
      t_xpd = -999;
      t_odt = -999;
      foreach (t_rd[i]) begin
        t_rd[i] = -999;
        t_ras[i] = -999;
        t_dal[i] = 0;
      end
      opn = '0;
      pcke = 1'h1;
      podt = 1'h0;
      in_sr = 1'h0;
      act_pd = 1'h0;
      slow_mode = 1'h0;
      se_strobe = 1'h0;
    end else begin
      now++;
      bl2 = cfg_bl8 ? 4 : 2;
      wl = int'(cfg_al) + int'(cfg_cl) - 1;
      lim = (cfg_grade800 ? XARDS_800 : XARDS_667) - int'(cfg_al);
      c = {ddr.ras_n, ddr.cas_n, ddr.we_n};
      if (!ck_en) chk(now - t_cke >= DLY_CYC && !ddr.cke, "early clock stop");
      if (ddr.odt != podt) begin
        chk(now - t_xpd >= AXPD_CYC && ddr.cke, "termination change");
        t_odt = now;
      end
      if (ddr.cke != pcke) begin
        chk(now - t_cke >= CKE_CYC, "short clock enable pulse");
        t_cke = now;
        if (!ddr.cke) begin
          chk(now - t_odt >= ANPD_CYC, "termination not settled");
          in_sr = !ddr.cs_n && c == 3'h1;
          act_pd = |opn;
        end else if (in_sr) t_xsr = now;
        else t_xpd = now;
      end else if (ddr.cke && !ddr.cs_n && c != 3'h7) begin
        chk(now - t_mrd >= MRD_CYC, "command after mode set");
        chk(now - t_xpd >= XP_CYC, "command after power down exit");
        if (c == 3'h5) chk(now - t_xsr >= XSRD_CYC, "read after self refresh");
        else chk(now - t_xsr >= XSNR_CYC, "command after self refresh");
        case (c)
          3'h3: begin
            chk(now - t_act >= RRD_CYC && now >= t_dal[ddr.ba], "activate spacing");
            t_act = now;
            t_ras[ddr.ba] = now;
            opn[ddr.ba] = 1'h1;
          end
          3'h5, 3'h4: begin
            chk(now - t_col >= CCD_CYC && (c == 3'h4 || now >= t_wtr), "column spacing");
            if (c == 3'h5 && act_pd && slow_mode) chk(now - t_xpd >= lim, "slow exit read");
            t_col = now;
            if (c == 3'h5) t_rd[ddr.ba] = now;
            else t_wtr = now + wl + bl2 + WTR_CYC;
            if (c == 3'h4 && ddr.addr[AP_BIT]) begin
              t_dal[ddr.ba] = now + wl + bl2 + WR_CYC + RP_CYC;
              opn[ddr.ba] = 1'h0;
            end
          end
          3'h2: for (int b = 0; b < 4; b++) begin
            if (opn[b] && (ddr.addr[AP_BIT] || ddr.ba == b)) begin
              chk(now - t_rd[b] >= cfg_al + bl2 && now - t_rd[b] >= RTP_CYC
                  && now - t_ras[b] >= RAS_CYC, "read to precharge");
              opn[b] = 1'h0;
            end
          end
          3'h0: begin
            t_mrd = now;
            if (ddr.ba == BA_MR) slow_mode = ddr.addr[MR_SLOW_BIT];
            // extended mode writes take effect at the command edge, inside the drive delay limit
            if (ddr.ba == BA_EMR) se_strobe = ddr.addr[EMR_DQS_BIT];
          end
          default: ;
        endcase
      end
      pcke = ddr.cke;
      podt = ddr.odt;
    end
  end
endmodule : ddr2_dev_model
`default_nettype wire

// file: ddr2_cmd_ctrl_test.sv
// self-checking bench for the ddr2 command controller
`timescale 1ns/1ps
`default_nettype none
module ddr2_cmd_ctrl_test
  import ddr2_timing_pkg::*;
();
  logic       clk_sys, rst, req_valid, req_ready, odt_req, cfg_bl8, cfg_grade800;
  logic       ck_en, dqs_se, slow_exit, dev_slow, dev_se;
  logic [2:0] cfg_al, cfg_cl;
  req_t       req;
  ddr_bus_t   ddr;
  int         faults, cyc, wl, bl2, al, rtp;
  int         mismatches = 0;
  int         compares = 0;

  ddr2_cmd_ctrl i_ddr2_cmd_ctrl (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .cfg_al(cfg_al), .cfg_cl(cfg_cl), .cfg_bl8(cfg_bl8),
    .cfg_grade800(cfg_grade800), .odt_req(odt_req), .ddr(ddr), .ck_en(ck_en),
    .dqs_se(dqs_se), .slow_exit(slow_exit));
  ddr2_dev_model i_ddr2_dev_model (.clk_sys(clk_sys), .rst(rst), .ddr(ddr), .ck_en(ck_en),
    .cfg_al(cfg_al), .cfg_cl(cfg_cl), .cfg_bl8(cfg_bl8), .cfg_grade800(cfg_grade800),
    .faults(faults), .slow_mode(dev_slow), .se_strobe(dev_se));

  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // updated late in the step so every task reads the count of the edge it woke on
  always @(posedge clk_sys) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input bit ok, input string m);
    compares++;
    if (!ok) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // leaves the request up so a following issue can go back to back
  task automatic issue(input cmd_t c, input logic [1:0] b, input logic [12:0] a, output int t);
    int n;
    req <= '{cmd: c, ba: b, addr: a};
    req_valid <= 1'h1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (req_ready !== 1'h1 && n < 1000);
    @(posedge clk_sys);
    t = cyc;
    if (n >= 1000) check(1'h0, "request never taken");
  endtask : issue

  task automatic idle(input int n);
    req_valid <= 1'h0;
    repeat (n) @(posedge clk_sys);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_bank();
    int a0, a1, r0, r1, p;
    issue(CMD_ACT, 2'h0, 13'h0010, a0);
    issue(CMD_ACT, 2'h1, 13'h0020, a1);
    check(a1 - a0 == RRD_CYC, "activate gap");
    issue(CMD_RD, 2'h0, 13'h0000, r0);
    issue(CMD_RD, 2'h1, 13'h0008, r1);
    check(r1 - r0 == CCD_CYC, "read gap");
    issue(CMD_PRE, 2'h0, 13'h0000, p);
    check(p - r0 >= rtp && p - a0 >= RAS_CYC, "read to precharge gap");
    issue(CMD_PRE, 2'h0, 13'h0400, p);
    idle(1);
    $display("bank test done");
  endtask : t_bank

  task automatic t_write();
    int a, w, r;
    issue(CMD_ACT, 2'h2, 13'h0030, a);
    issue(CMD_WR, 2'h2, 13'h0000, w);
    issue(CMD_RD, 2'h2, 13'h0000, r);
    check(r - w >= wl + bl2 + WTR_CYC, "write to read gap");
    issue(CMD_WRA, 2'h2, 13'h0000, w);
    issue(CMD_ACT, 2'h2, 13'h0030, a);
    check(a - w >= wl + bl2 + WR_CYC + RP_CYC, "auto precharge recovery");
    issue(CMD_PRE, 2'h2, 13'h0000, r);
    idle(1);
    $display("write test done");
  endtask : t_write

  task automatic t_mode();
    int m0, m1;
    // refresh waits for the idle gates, then an empty slot that is always taken, before the mode writes
    issue(CMD_REF, 2'h0, 13'h0000, m0);
    issue(CMD_NOP, 2'h0, 13'h0000, m0);
    issue(CMD_MRS, BA_MR, 13'h1000, m0);
    issue(CMD_MRS, BA_EMR, 13'h0400, m1);
    check(m1 - m0 >= MRD_CYC, "mode set gap");
    idle(2);
    check(slow_exit === 1'h1, "slow exit not selected");
    check(dqs_se === 1'h1, "single strobe not selected");
    check(dev_slow === 1'h1, "device did not see slow exit");
    check(dev_se === 1'h1, "device did not see single strobe");
    $display("mode test done");
  endtask : t_mode

  task automatic t_pd(input logic [12:0] mr, input int gap);
    int t, e, r;
    issue(CMD_MRS, BA_MR, mr, t);
    issue(CMD_ACT, 2'h0, 13'h0040, t);
    check(slow_exit === mr[MR_SLOW_BIT], "exit mode");
    issue(CMD_PDE, 2'h0, 13'h0000, t);
    issue(CMD_EXIT, 2'h0, 13'h0000, e);
    check(e - t >= CKE_CYC, "power down pulse");
    issue(CMD_RD, 2'h0, 13'h0000, r);
    check(r - e == gap, "active power down exit to read");
    issue(CMD_PRE, 2'h0, 13'h0400, t);
    issue(CMD_PDE, 2'h0, 13'h0000, t);
    issue(CMD_EXIT, 2'h0, 13'h0000, e);
    issue(CMD_ACT, 2'h1, 13'h0040, r);
    check(r - e == XP_CYC, "precharge power down exit");
    issue(CMD_PRE, 2'h0, 13'h0400, t);
    idle(1);
    $display("power down test done");
  endtask : t_pd

  task automatic t_odt();
    int o, p, e, n;
    o = cyc;
    odt_req <= 1'h1;
    issue(CMD_PDE, 2'h0, 13'h0000, p);
    check(p - o >= ANPD_CYC, "termination settle before power down");
    issue(CMD_EXIT, 2'h0, 13'h0000, e);
    odt_req <= 1'h0;
    req_valid <= 1'h0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (ddr.odt !== 1'h0 && n < 100);
    check(n >= AXPD_CYC && n < 100, "termination frozen after exit");
    @(posedge clk_sys);
    $display("termination test done");
  endtask : t_odt

  task automatic t_sref();
    int s, e, a, r;
    issue(CMD_SRE, 2'h0, 13'h0000, s);
    req_valid <= 1'h0;
    repeat (4) @(negedge clk_sys);
    check(ck_en === 1'h0, "clock still running in self refresh");
    @(posedge clk_sys);
    issue(CMD_EXIT, 2'h0, 13'h0000, e);
    issue(CMD_ACT, 2'h1, 13'h0050, a);
    check(a - e >= XSNR_CYC, "self refresh exit to activate");
    issue(CMD_RD, 2'h1, 13'h0000, r);
    check(r - e >= XSRD_CYC, "self refresh exit to read");
    issue(CMD_PRE, 2'h1, 13'h0000, s);
    idle(2);
    $display("self refresh test done");
  endtask : t_sref

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1;
    req_valid = 1'h0;
    req = '0;
    odt_req = 1'h0;
    cfg_al = 3'h1;
    cfg_cl = 3'h3;
    cfg_bl8 = 1'h1;
    cfg_grade800 = 1'h1;
    cyc = 0;
    al = int'(cfg_al);
    wl = al + int'(cfg_cl) - 1;
    bl2 = 4;
    rtp = (al + bl2 > RTP_CYC) ? al + bl2 : RTP_CYC;
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    @(negedge clk_sys);
    check(ddr === ddr_bus_t'{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 2'h0, 13'h0000, 1'h0}, "reset pins");
    check({ck_en, dqs_se, slow_exit} === 3'h4, "reset status");
    @(posedge clk_sys);
    t_bank();
    t_write();
    t_mode();
    t_pd(13'h1000, XARDS_800 - al);
    // the slower grade and the short burst change the slow exit and precharge gaps
    cfg_grade800 <= 1'h0;
    cfg_bl8 <= 1'h0;
    t_pd(13'h1000, XARDS_667 - al);
    t_pd(13'h0000, XARD_CYC);
    t_odt();
    t_sref();
    check(faults === 0, "device model saw spacing faults");
    stop_test();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule : ddr2_cmd_ctrl_test
`default_nettype wire
